// file: ssd_core.sv
// sync serial duplex shift unit, 8-bit words, internal or external shift clock
// assumes: register master on clk; serial pins asynchronous to clk
//
// Functional notes
// RULE_01: external clock receive always double buffered
// RULE_02: receive-done pulse on each buffer transfer
// RULE_03: single buffer internal clock starts on write
// RULE_04: single buffer: rx done, tx done, clock halts
// RULE_05: next exchange needs read and write both
// RULE_06: double buffer internal clock starts on write
// RULE_07: double buffer: tx done, reload next word
// RULE_08: clock stalls on empty tx or full rx
// RULE_09: resume after read and new write
// RULE_10: external clock rx double buffered regardless
// RULE_11: external single buffer shifts buffered word out
// RULE_12: external clock rx done on buffer transfer
// RULE_13: software writes tx before next word clocks
// RULE_14: software reads rx before next word ends
// RULE_15: external double buffer tx done on reload
// RULE_16: peer clock shifts out and in together
// RULE_17: overrun when rx unread at last bit
// RULE_18: underrun drives idle level, sets flag
// RULE_19: sync mode when mode select is 00
// RULE_20: words are eight bits
// RULE_21: interrupts are one-cycle pulses
`timescale 1ns/10ps
`include "ssd_map.svh"

module ssd_core
  import ssd_pkg::*;
#(
  parameter int SCLK_HALF = `SSD_SCLK_HALF  // clk cycles per half shift clock
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        shift_clock_pin_in,
  output logic             shift_clock_pin_out,
  output logic             shift_clock_pin_oe,
  input  wire logic        serial_in_pin,
  output logic             serial_out_pin,
  output logic             rx_done_irq,
  output logic             tx_done_irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic       sck_m;       // clock pin, first stage
  logic       sck_s;       // clock pin, synced
  logic       sck_d;       // synced clock, delayed for edges
  logic       sdi_m;       // data pin, first stage
  logic       sdi_s;       // data pin, synced

  // two flops on every pin, third for edge finding
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_m <= 1'b1;
      sck_s <= 1'b1;
      sck_d <= 1'b1;
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
    end else begin
      sck_m <= shift_clock_pin_in;
      sck_s <= sck_m;
      sck_d <= sck_s;
      sdi_m <= serial_in_pin;
      sdi_s <= sdi_m;
    end
  end

  // ----------------------------------------------------------------
  // main state
  // ----------------------------------------------------------------
  ssd_state_t st;        // registered state
  ssd_state_t next_st;   // next state
  logic       mode_ok;   // sync mode selected
  logic       ext;       // peer drives the clock
  logic       dbe;       // double buffering on
  logic       fall;      // shift clock falling edge
  logic       rise;      // shift clock rising edge
  logic       rd_rx;     // receive buffer read this cycle
  logic       wr_tx;     // transmit buffer write this cycle
  logic       rx_busy;   // rx buffer still unread after this cycle
  logic       tick;      // half period of internal clock elapsed

  assign mode_ok = (st.ctrl.serial_mode_select == `SSD_MODE_SYNC);  // RULE_19
  assign ext     = st.ctrl.ext_clock;
  assign dbe     = st.ctrl.double_buffer_enable;
  assign rd_rx   = rd && (addr == `SSD_ADDR_RXBUF);
  assign wr_tx   = wr && (addr == `SSD_ADDR_TXBUF);
  assign rx_busy = st.rx_full && !rd_rx;
  assign tick    = (st.div == 8'(SCLK_HALF - 1));

  // status word as software sees it
  function automatic logic [31:0] status_word(input ssd_state_t s);
    logic [31:0] w;
    w = 32'h0;
    w[`SSD_ST_TBE]  = !s.tx_full;              // tx_buffer_empty_flag
    w[`SSD_ST_RBF]  = s.rx_full;               // rx_buffer_full_flag
    w[`SSD_ST_OVR]  = s.ovr;
    w[`SSD_ST_UDR]  = s.udr;
    w[`SSD_ST_BUSY] = (s.phase == SSD_SHIFT);  // word in flight
    return w;
  endfunction

  // next state: bus, buffers, shifter
  always_comb begin
    next_st = st;
    next_st.txirq = 1'b0;               // RULE_21
    next_st.rxirq = 1'b0;               // RULE_21
    next_st.rdata = 32'h0;
    fall = 1'b0;
    rise = 1'b0;

    // register reads, answered next cycle
    if (rd) begin
      unique case (addr)
        `SSD_ADDR_CTRL:   next_st.rdata = {27'h0, st.ctrl};
        `SSD_ADDR_STATUS: next_st.rdata = status_word(st);
        `SSD_ADDR_RXBUF:  next_st.rdata = {24'h0, st.rx_buf};
        default:          next_st.rdata = 32'h0;  // unmapped reads zero
      endcase
    end
    // register writes
    if (wr && addr == `SSD_ADDR_CTRL) begin
      next_st.ctrl = wdata[`SSD_CTRL_W-1:0];
    end
    if (wr && addr == `SSD_ADDR_STATUS) begin
      // write one clears; a set below wins
      if (wdata[`SSD_ST_OVR]) begin
        next_st.ovr = 1'b0;
      end
      if (wdata[`SSD_ST_UDR]) begin
        next_st.udr = 1'b0;
      end
    end
    if (rd_rx) begin
      next_st.rx_full = 1'b0;
    end
    if (wr_tx) begin
      next_st.tx_buf  = wdata[7:0];
      next_st.tx_full = 1'b1;
    end

    // edge source: synced pin or own divider
    if (ext) begin
      fall = sck_d && !sck_s;
      rise = !sck_d && sck_s;
    end else if (st.phase == SSD_SHIFT && tick) begin
      fall = st.sclk_o;
      rise = !st.sclk_o;
    end

    unique case (st.phase)
      SSD_IDLE: begin
        next_st.bit_cnt = 4'd0;
        next_st.div     = 8'd0;
        next_st.sclk_o  = 1'b1;
        if (!mode_ok) begin
          // unit parked outside sync mode
        end else if (ext) begin
          // with double buffering on, an empty shifter takes a fresh word at once
          if (dbe && !st.tx_loaded && next_st.tx_full) begin
            next_st.tx_sh     = next_st.tx_buf;         // RULE_15
            next_st.tx_full   = 1'b0;
            next_st.tx_loaded = 1'b1;
            next_st.txirq     = 1'b1;
          end
          if (fall) begin
            next_st.phase    = SSD_SHIFT;               // RULE_16
            next_st.udr_word = 1'b0;
            if (st.tx_loaded) begin
              next_st.sdo = st.tx_sh[0];
            end else if (!dbe && st.tx_full) begin
              next_st.tx_sh     = st.tx_buf;            // RULE_11
              next_st.tx_full   = wr_tx;
              next_st.tx_loaded = 1'b1;
              next_st.sdo       = st.tx_buf[0];
            end else begin
              next_st.udr      = 1'b1;                  // RULE_18
              next_st.udr_word = 1'b1;
              next_st.sdo      = st.ctrl.idle_line_level;  // RULE_18
            end
          end
        end else if (!st.rx_full && (st.tx_full || (dbe && st.tx_loaded))) begin
          // internal clock: start once tx waits and rx is free
          next_st.phase    = SSD_SHIFT;      // RULE_03 RULE_05 RULE_06 RULE_09
          next_st.udr_word = 1'b0;
          if (st.tx_loaded) begin
            next_st.sdo = st.tx_sh[0];
          end else begin
            next_st.tx_sh     = st.tx_buf;
            next_st.tx_full   = wr_tx;
            next_st.tx_loaded = 1'b1;
            next_st.sdo       = st.tx_buf[0];
          end
        end
      end
      SSD_SHIFT: begin
        // internal divider drives the pin clock
        if (!ext) begin
          next_st.div = tick ? 8'd0 : st.div + 8'd1;
          if (tick) begin
            next_st.sclk_o = !st.sclk_o;
          end
        end
        // later bits change on falling edges
        if (fall && st.bit_cnt != 4'd0) begin
          next_st.tx_sh = {1'b0, st.tx_sh[7:1]};
          next_st.sdo   = st.udr_word ? st.ctrl.idle_line_level : st.tx_sh[1];
        end
        // sample on rising edges
        if (rise) begin
          next_st.rx_sh   = {sdi_s, st.rx_sh[7:1]};                 // RULE_16
          next_st.bit_cnt = st.bit_cnt + 4'd1;
          if (st.bit_cnt == `SSD_WORD_BITS - 4'd1) begin            // RULE_20
            next_st.phase     = SSD_IDLE;                           // RULE_04 RULE_08
            next_st.tx_loaded = 1'b0;
            if (rx_busy) begin
              next_st.ovr = 1'b1;                                   // RULE_17
            end else begin
              next_st.rx_buf  = {sdi_s, st.rx_sh[7:1]};  // RULE_01 RULE_10
              next_st.rx_full = 1'b1;
              next_st.rxirq   = 1'b1;                    // RULE_02 RULE_12
            end
            if (!st.udr_word && !(ext && dbe)) begin
              next_st.txirq = 1'b1;                      // RULE_04 RULE_11
            end
            if (dbe && next_st.tx_full) begin
              next_st.tx_sh     = next_st.tx_buf;        // RULE_07 RULE_15
              next_st.tx_full   = 1'b0;
              next_st.tx_loaded = 1'b1;
              next_st.txirq     = 1'b1;                  // RULE_07 RULE_15
            end
          end
        end
        if (!mode_ok) begin
          next_st.phase = SSD_IDLE;    // abandon word on mode change
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      st         <= '0;
      st.ctrl    <= `SSD_CTRL_RST;
      st.phase   <= SSD_IDLE;
      st.sclk_o  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata               = st.rdata;
  assign shift_clock_pin_out = st.sclk_o;
  assign shift_clock_pin_oe  = mode_ok && !ext;   // drive only when clock is ours
  assign serial_out_pin      = st.sdo;
  assign rx_done_irq         = st.rxirq;          // RULE_21
  assign tx_done_irq         = st.txirq;          // RULE_21

endmodule

// file: ssd_map.svh
// register offsets, field positions and counts for the sync serial unit
// assumes: included by the package and the core by bare name
`ifndef SSD_MAP_SVH
`define SSD_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SSD_ADDR_CTRL    8'h00
`define SSD_ADDR_STATUS  8'h04
`define SSD_ADDR_TXBUF   8'h08
`define SSD_ADDR_RXBUF   8'h0c

// ----------------------------------------------------------------
// field positions and values
// ----------------------------------------------------------------
`define SSD_CTRL_W       5
`define SSD_CTRL_RST     5'h00
`define SSD_MODE_SYNC    2'b00
`define SSD_ST_TBE       0
`define SSD_ST_RBF       1
`define SSD_ST_OVR       2
`define SSD_ST_UDR       3
`define SSD_ST_BUSY      4
`define SSD_WORD_BITS    4'd8
`define SSD_SCLK_HALF    4

`endif

// file: ssd_pkg.sv
// types shared by the sync serial unit
// assumes: ssd_map.svh sits in the same folder
package ssd_pkg;
  `include "ssd_map.svh"

  // word shifter phase
  typedef enum logic {SSD_IDLE, SSD_SHIFT} ssd_phase_t;

  // software control word
  typedef struct packed {
    logic       idle_line_level;       // level driven on underrun
    logic       ext_clock;             // 1: peer drives shift clock
    logic       double_buffer_enable;  // transmit double buffering
    logic [1:0] serial_mode_select;    // 00 selects sync mode
  } ssd_ctrl_t;

  // whole state of the unit
  typedef struct packed {
    ssd_ctrl_t  ctrl;
    ssd_phase_t phase;
    logic [7:0] tx_buf;
    logic       tx_full;
    logic [7:0] tx_sh;
    logic       tx_loaded;
    logic [7:0] rx_buf;
    logic       rx_full;
    logic [7:0] rx_sh;
    logic [3:0] bit_cnt;
    logic [7:0] div;
    logic       sclk_o;
    logic       sdo;
    logic       udr_word;
    logic       ovr;
    logic       udr;
    logic       txirq;
    logic       rxirq;
    logic [31:0] rdata;
  } ssd_state_t;
endpackage

// file: ssd_core_sva.sv
// assertions on the ssd_core ports
// assumes: bound into every ssd_core, one clock domain, bench keeps SCLK_HALF at 4
`timescale 1ns/10ps
`include "ssd_map.svh"
module ssd_core_chk #(
  parameter int SCLK_HALF = 4  // clk cycles per half shift clock
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        shift_clock_pin_out,
  input wire logic        shift_clock_pin_oe,
  input wire logic        rx_done_irq,
  input wire logic        tx_done_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] ctl;     // shadow of control word
  logic [7:0] lo_n;    // low cycles of shift clock
  logic [3:0] fall_n;  // clock falls since last word
  logic       unread;  // received word not yet read
  logic       sclk_q;  // shift clock one cycle ago
  // ----
  // helper state
  // ----
  always_ff @(posedge clk) begin
    sclk_q <= shift_clock_pin_out;
    lo_n <= shift_clock_pin_out ? 8'h00 : lo_n + 8'h01;
    if (rst) ctl <= 5'h00;
    else if (wr && addr == `SSD_ADDR_CTRL) ctl <= wdata[4:0];
    if (rst || rx_done_irq || (wr && addr == `SSD_ADDR_CTRL)) fall_n <= 4'h0;
    else if (sclk_q && !shift_clock_pin_out) fall_n <= fall_n + 4'h1;
    if (rst) unread <= 1'b0;
    else if (rx_done_irq) unread <= 1'b1;
    else if (rd && addr == `SSD_ADDR_RXBUF) unread <= 1'b0;
  end
  // ----
  // properties
  // ----
  sequence s_high_hold; shift_clock_pin_out [*3]; endsequence
  property p_rx_pulse; rx_done_irq |=> !rx_done_irq; endproperty
  property p_tx_pulse; tx_done_irq |=> !tx_done_irq; endproperty
  property p_rdata_idle; !rd |=> rdata == 32'h0; endproperty
  property p_oe_mode; shift_clock_pin_oe == (ctl[1:0] == 2'b00 && !ctl[3]); endproperty
  property p_low_half;
    shift_clock_pin_oe && $rose(shift_clock_pin_out) |-> lo_n == SCLK_HALF;
  endproperty
  property p_word_len; shift_clock_pin_oe && rx_done_irq |-> fall_n == 4'h8; endproperty
  property p_stall; unread && shift_clock_pin_oe |-> !$fell(shift_clock_pin_out); endproperty
  property p_halt; shift_clock_pin_oe && tx_done_irq |-> s_high_hold; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx done too long");
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx done too long");
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  a_oe_mode: assert property (p_oe_mode) else $error("clock enable wrong");
  a_low_half: assert property (p_low_half) else $error("clock low time wrong");
  a_word_len: assert property (p_word_len) else $error("word not eight clocks");
  a_stall: assert property (p_stall) else $error("clock ran with rx full");
  a_halt: assert property (p_halt) else $error("clock not halted");
endmodule
bind ssd_core ssd_core_chk #(.SCLK_HALF(SCLK_HALF)) u_chk (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .shift_clock_pin_out(shift_clock_pin_out), .shift_clock_pin_oe(shift_clock_pin_oe),
  .rx_done_irq(rx_done_irq), .tx_done_irq(tx_done_irq));

// file: ssd_peer.sv
// far-side serial peer: clocks words when asked, swaps data lsb first
// assumes: line_clk is the resolved shift clock wire, idle high
`timescale 1ns/10ps
module ssd_peer (
  input  wire logic  line_clk,
  input  wire logic  sdi,
  output logic       sclk,
  output logic       sdo,
  output logic [7:0] rx_word
);
  logic [7:0] sh;    // word being sent
  logic       rose;  // a rise seen in this word
  initial begin
    sclk = 1'b1;
    sh = 8'h00;
    rose = 1'b0;
    rx_word = 8'h00;
  end
  assign sdo = sh[0];
  // sample on rise, change on later falls
  always @(posedge line_clk) begin
    rx_word <= {sdi, rx_word[7:1]};
    rose <= 1'b1;
  end
  always @(negedge line_clk) if (rose) sh <= {~sh[0], sh[7:1]};
  task automatic load(input logic [7:0] w);
    sh = w;
    rose = 1'b0;
  endtask
  // eight clock periods of 320 ns, off phase with clk
  task automatic send();
    #7;
    repeat (8) begin
      #160 sclk = 1'b0;
      #160 sclk = 1'b1;
    end
  endtask
endmodule

// file: tb_ssd_core.sv
// testbench for ssd_core: register driver, serial peer, bound checker
// assumes: ssd_pkg, ssd_core, ssd_peer and checker compiled first
`timescale 1ns/10ps
`include "ssd_map.svh"
module tb_ssd_core;
  logic        clk, rst, wr, rd;
  logic [7:0]  addr, t, r, t2, r2;
  logic [31:0] wdata, rdata, v;
  logic        sclk_out, oe, sout, rxi, txi;
  wire logic   line_clk, peer_sclk, peer_sdo;
  wire logic [7:0] peer_rx;
  int seed = 92821, num_errors = 0, n_compared = 0, n_rx = 0, n_tx = 0, cyc = 0;
  assign line_clk = oe ? sclk_out : peer_sclk;
  ssd_core #(.SCLK_HALF(4)) dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .shift_clock_pin_in(line_clk), .shift_clock_pin_out(sclk_out),
    .shift_clock_pin_oe(oe), .serial_in_pin(peer_sdo), .serial_out_pin(sout),
    .rx_done_irq(rxi), .tx_done_irq(txi));
  ssd_peer peer (.line_clk(line_clk), .sdi(sout), .sclk(peer_sclk), .sdo(peer_sdo),
    .rx_word(peer_rx));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----
  // tasks
  // ----
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (n_rx < n && k < 600) begin
      @(negedge clk);
      k++;
    end
    chk("rx done count", n_rx, n);
    @(posedge clk);
  endtask
  // irq count and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rxi === 1'b1) n_rx <= n_rx + 1;
    if (txi === 1'b1) n_tx <= n_tx + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(8'h10, v);
    chk("unmapped", v, 32'h0);
    wreg(`SSD_ADDR_CTRL, 32'h1);
    chk("clock enable", oe, 1'b0);
    wreg(`SSD_ADDR_CTRL, 32'h0);
    t = 8'($random(seed));
    r = 8'($random(seed));
    peer.load(r);
    wreg(`SSD_ADDR_TXBUF, {24'h0, t});
    for (int i = 1; i <= 4; i++) begin
      wait_rx(i);
      chk("peer word", peer_rx, t);
      t = (i == 1) ? 8'h00 : (i == 2) ? 8'hff : 8'($random(seed));
      wreg(`SSD_ADDR_TXBUF, {24'h0, t});
      repeat (24) @(posedge clk);
      chk("held clock", sclk_out, 1'b1);
      r2 = r;
      r = 8'($random(seed));
      peer.load(r);
      rreg(`SSD_ADDR_RXBUF, v);
      chk("rx word", v, {24'h0, r2});
    end
    wait_rx(5);
    chk("peer word", peer_rx, t);
    chk("tx done count", n_tx, 5);
    rreg(`SSD_ADDR_RXBUF, v);
    chk("rx word", v, {24'h0, r});
    wreg(`SSD_ADDR_CTRL, 32'h4);
    t = 8'($random(seed));
    t2 = 8'($random(seed));
    r = 8'($random(seed));
    r2 = 8'($random(seed));
    peer.load(r);
    wreg(`SSD_ADDR_TXBUF, {24'h0, t});
    wreg(`SSD_ADDR_TXBUF, {24'h0, t2});
    wait_rx(6);
    chk("peer word", peer_rx, t);
    peer.load(r2);
    repeat (24) @(posedge clk);
    chk("held clock", sclk_out, 1'b1);
    rreg(`SSD_ADDR_RXBUF, v);
    chk("rx word", v, {24'h0, r});
    wait_rx(7);
    chk("tx done count", n_tx, 7);
    chk("peer word", peer_rx, t2);
    rreg(`SSD_ADDR_RXBUF, v);
    chk("rx word", v, {24'h0, r2});
    for (int i = 8; i <= 9; i++) begin
      // first word single buffered, second double buffered
      wreg(`SSD_ADDR_CTRL, (i == 8) ? 32'h18 : 32'h1c);
      t = 8'($random(seed));
      r = 8'($random(seed));
      wreg(`SSD_ADDR_TXBUF, {24'h0, t});
      peer.load(r);
      peer.send();
      wait_rx(i);
      chk("peer word", peer_rx, t);
      if (i == 8) begin
        // read before the next word ends; the second word stays unread
        rreg(`SSD_ADDR_RXBUF, v);
        chk("rx word", v, {24'h0, r});
      end
    end
    chk("tx done count", n_tx, 9);
    peer.load(~r);
    peer.send();
    repeat (8) @(posedge clk);
    chk("idle level", peer_rx, 8'hff);
    chk("rx done count", n_rx, 9);
    rreg(`SSD_ADDR_STATUS, v);
    chk("run errors", v[3:2], 2'b11);
    rreg(`SSD_ADDR_RXBUF, v);
    chk("kept word", v, {24'h0, r});
    finish_test();
  end
endmodule
